//--- src/bdc_pkg.sv
// package: constants for the buck enable and voltage scaling control block
// Functional notes
// R1: converter enables in slot 1..15 or pin
// R2: request pins map to any resource
// R3: soft start begins after startup delay
// R4: pa ramp bit 1 selects short timing
// R5: new voltage by register write or select
// R6: select pin acts only on mapped converters
// R7: direct jump bit 1 jumps, else ramp
// R8: one code step per step interval
// R9: forced pwm while voltage is moving
// R10: analog mode bypasses scaling, tracks input
// R11: scaling runs only while converter enabled
// R12: target changed while off ramps at enable
// R13: paired converters high side half period apart
// R14: undervoltage lockout disables every resource
// R15: discharge active while resource disabled
// R16: power good follows undervoltage comparator
// R17: power good blanked when off or moving
// R18: mapped pin overrides register enable bit
// R19: select low primary, high alternate setting
// R20: pins synchronized before use
package bdc_pkg;
  localparam int NUM_BUCK = 3;
  localparam int NUM_RES  = 5;
  localparam int VW       = 7;
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL0   = 8'h00;
  localparam logic [7:0] ADDR_CTRL1   = 8'h04;
  localparam logic [7:0] ADDR_CTRL2   = 8'h08;
  localparam logic [7:0] ADDR_VOLT0   = 8'h0c;
  localparam logic [7:0] ADDR_VOLT1   = 8'h10;
  localparam logic [7:0] ADDR_VOLT2   = 8'h14;
  localparam logic [7:0] ADDR_ENABLE  = 8'h18;
  localparam logic [7:0] ADDR_STATUS  = 8'h1c;
  localparam logic [7:0] ADDR_CURRENT = 8'h20;
  // control register fields
  localparam int CTRL_SLOT_LSB   = 0;
  localparam int CTRL_SEL_MAP    = 4;
  localparam int CTRL_DIRECT     = 5;
  localparam int CTRL_STEP_LSB   = 6;
  localparam int CTRL_PSAVE      = 9;
  localparam int CTRL_RAMP_FAST  = 10;
  localparam int CTRL_ANALOG     = 11;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0200;
  // volt register: primary [6:0], alternate [14:8]
  localparam int VOLT_ALT_LSB    = 8;
  localparam logic [31:0] VOLT_RESET = 32'h0000_4040;
  // enable register: en[4:0], map_a[12:8], map_b[20:16]
  localparam int EN_MAP_A_LSB    = 8;
  localparam int EN_MAP_B_LSB    = 16;
  // timing
  localparam int CLK_MHZ         = 100;
  localparam int SLOT_US         = 1;
  localparam int SLOT_CYC        = SLOT_US * CLK_MHZ;
  localparam int START_US        = 130;
  localparam int START_CYC       = START_US * CLK_MHZ;
  localparam int START_FAST_US   = 65;
  localparam int START_FAST_CYC  = START_FAST_US * CLK_MHZ;
  localparam int STEP_BASE_NS    = 500;
  localparam int STEP_BASE_CYC   = (STEP_BASE_NS * CLK_MHZ) / 1000;
  localparam int SW_PERIOD_CYC   = 44;
  localparam int SW_HALF_CYC     = SW_PERIOD_CYC / 2;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : bdc_pkg

//--- src/bdc_sync.sv
// two flop synchronizer for pin inputs
module bdc_sync #(
  parameter int W = 1
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d; // R20
      q    <= meta;
    end
  end
endmodule : bdc_sync

//--- src/bdc_dvs.sv
// per converter voltage scaling and soft start sequencer
module bdc_dvs #(
  parameter int START_CYCLES = bdc_pkg::START_CYC,
  parameter int FAST_CYCLES  = bdc_pkg::START_FAST_CYC
) (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic                 enable,
  input  wire logic                 fast_start,
  input  wire logic                 direct,
  input  wire logic [2:0]           step_sel,
  input  wire logic                 analog_mode,
  input  wire logic [bdc_pkg::VW-1:0] target,
  output logic      [bdc_pkg::VW-1:0] current,
  output logic                      soft_start,
  output logic                      running,
  output logic                      moving
);
  typedef enum logic [1:0] {BDC_OFF, BDC_DELAY, BDC_RUN} bdc_state_t;
  bdc_state_t state;
  logic [15:0] cnt;
  logic [15:0] step_cnt;
  logic [15:0] step_len;

  assign step_len = 16'(bdc_pkg::STEP_BASE_CYC << step_sel);

  always_ff @(posedge aclk) begin
    if (!aresetn || !enable) begin
      state      <= BDC_OFF; // R11
      cnt        <= '0;
      soft_start <= 1'b0;
    end else begin
      case (state)
        BDC_OFF: begin
          state <= BDC_DELAY;
          cnt   <= fast_start ? 16'(FAST_CYCLES - 1) : 16'(START_CYCLES - 1); // R4
        end
        BDC_DELAY: begin
          if (cnt == 16'h0000) begin
            state      <= BDC_RUN;
            soft_start <= 1'b1; // R3
          end else begin
            cnt <= cnt - 16'h0001;
          end
        end
        BDC_RUN: soft_start <= 1'b0;
        default: state <= BDC_OFF;
      endcase
    end
  end

  assign running = (state == BDC_RUN);

  // current code keeps last value while off so a new target ramps on enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      current  <= target;
      step_cnt <= '0;
    end else if (state == BDC_RUN && !analog_mode) begin // R10 R11 R12
      if (current == target) begin
        step_cnt <= '0;
      end else if (direct) begin
        current <= target; // R7
      end else if (step_cnt >= step_len - 16'h0001) begin
        step_cnt <= '0;
        current  <= (current < target) ? current + 1'b1 : current - 1'b1; // R8
      end else begin
        step_cnt <= step_cnt + 16'h0001;
      end
    end else begin
      step_cnt <= '0;
    end
  end

  assign moving = running && !analog_mode && (current != target); // R9 R17
endmodule : bdc_dvs

//--- src/bdc_top.sv
// top: axi4-lite registers, enable sequencing, scaling and pin control
//
// The register addresses and the AXI4-Lite register port were left to the implementer.
module bdc_top #(
  parameter int START_CYCLES = bdc_pkg::START_CYC,
  parameter int FAST_CYCLES  = bdc_pkg::START_FAST_CYC,
  parameter int SLOT_CYCLES  = bdc_pkg::SLOT_CYC
) (
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  input  wire logic [7:0]                  s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic      [1:0]                  s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [7:0]                  s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic      [31:0]                 s_axi_rdata,
  output logic      [1:0]                  s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  input  wire logic                        resource_request_pin_a,
  input  wire logic                        resource_request_pin_b,
  input  wire logic                        voltage_select_pin,
  input  wire logic                        power_on,
  input  wire logic                        uvlo,
  input  wire logic [bdc_pkg::NUM_BUCK-1:0] uv_comp,
  output logic      [bdc_pkg::NUM_RES-1:0]  res_enable,
  output logic      [bdc_pkg::NUM_RES-1:0]  res_discharge,
  output logic      [bdc_pkg::NUM_BUCK-1:0] soft_start,
  output logic      [bdc_pkg::NUM_BUCK-1:0] force_pwm,
  output logic      [bdc_pkg::NUM_BUCK-1:0] power_good,
  output logic      [bdc_pkg::NUM_BUCK*bdc_pkg::VW-1:0] vout_code,
  output logic                             analog_track,
  output logic                             phase_clk_a,
  output logic                             phase_clk_b
);
  localparam int NB = bdc_pkg::NUM_BUCK;
  localparam int NR = bdc_pkg::NUM_RES;
  localparam int VW = bdc_pkg::VW;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [31:0] ctrl [NB];
  logic [31:0] volt [NB];
  logic [31:0] en_reg;
  logic [3:0]  slot_now;
  logic [15:0] slot_cnt;
  logic [2:0]  pins_q;
  logic        uvlo_q;
  logic        pon_q;
  logic [NB-1:0] uv_q;
  logic [NR-1:0] en_eff;
  logic [NB-1:0] buck_run;
  logic [NB-1:0] buck_moving;
  logic [NB-1:0] buck_ss;
  logic [NB*VW-1:0] cur_codes;

  bdc_sync #(.W(3)) u_pin_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       ({voltage_select_pin, resource_request_pin_b, resource_request_pin_a}),
    .q       (pins_q)
  ); // R20

  bdc_sync #(.W(NB + 2)) u_ana_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       ({uv_comp, uvlo, power_on}),
    .q       ({uv_q, uvlo_q, pon_q})
  );

  // ----------------------------------------------------------------
  // axi4-lite slave
  // ----------------------------------------------------------------
  logic        aw_hold;
  logic        w_hold;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        do_write;
  logic        wr_hit;

  assign do_write = aw_hold && w_hold && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold       <= 1'b0;
      s_axi_awready <= 1'b0;
      aw_addr       <= 8'h00;
    end else if (do_write) begin
      aw_hold       <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold       <= 1'b1;
      aw_addr       <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_hold && !s_axi_bvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold       <= 1'b0;
      s_axi_wready <= 1'b0;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
    end else if (do_write) begin
      w_hold       <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold       <= 1'b1;
      w_data       <= s_axi_wdata;
      w_strb       <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_hold && !s_axi_bvalid;
    end
  end

  always_comb begin
    wr_hit = 1'b0;
    case (aw_addr)
      bdc_pkg::ADDR_CTRL0, bdc_pkg::ADDR_CTRL1, bdc_pkg::ADDR_CTRL2,
      bdc_pkg::ADDR_VOLT0, bdc_pkg::ADDR_VOLT1, bdc_pkg::ADDR_VOLT2,
      bdc_pkg::ADDR_ENABLE: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= bdc_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? bdc_pkg::RESP_OKAY : bdc_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  function automatic logic [31:0] bdc_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction : bdc_merge

  genvar gi;
  generate
    for (gi = 0; gi < NB; gi++) begin : g_reg
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          ctrl[gi] <= bdc_pkg::CTRL_RESET;
          volt[gi] <= bdc_pkg::VOLT_RESET;
        end else if (do_write) begin
          if (aw_addr == bdc_pkg::ADDR_CTRL0 + 8'(gi * 4)) begin
            ctrl[gi] <= bdc_merge(ctrl[gi], w_data, w_strb);
          end
          if (aw_addr == bdc_pkg::ADDR_VOLT0 + 8'(gi * 4)) begin
            volt[gi] <= bdc_merge(volt[gi], w_data, w_strb); // R5
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_reg <= 32'h0000_0000;
    end else if (do_write && aw_addr == bdc_pkg::ADDR_ENABLE) begin
      en_reg <= bdc_merge(en_reg, w_data, w_strb);
    end
  end

  logic [31:0] rd_val;
  logic        rd_hit;
  always_comb begin
    rd_hit = 1'b1;
    rd_val = 32'h0000_0000;
    case (s_axi_araddr)
      bdc_pkg::ADDR_CTRL0:   rd_val = ctrl[0];
      bdc_pkg::ADDR_CTRL1:   rd_val = ctrl[1];
      bdc_pkg::ADDR_CTRL2:   rd_val = ctrl[2];
      bdc_pkg::ADDR_VOLT0:   rd_val = volt[0];
      bdc_pkg::ADDR_VOLT1:   rd_val = volt[1];
      bdc_pkg::ADDR_VOLT2:   rd_val = volt[2];
      bdc_pkg::ADDR_ENABLE:  rd_val = en_reg;
      bdc_pkg::ADDR_STATUS:  rd_val = {16'h0000, 3'b000, res_enable, 1'b0, buck_moving,
                                       1'b0, power_good};
      bdc_pkg::ADDR_CURRENT: rd_val = 32'(cur_codes);
      default:               rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= bdc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_val;
      s_axi_rresp   <= rd_hit ? bdc_pkg::RESP_OKAY : bdc_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // power-up time slots
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn || !pon_q || uvlo_q) begin
      slot_now <= 4'h0;
      slot_cnt <= 16'h0000;
    end else if (slot_now != 4'hf) begin
      if (slot_cnt == 16'(SLOT_CYCLES - 1)) begin
        slot_cnt <= 16'h0000;
        slot_now <= slot_now + 4'h1; // R1
      end else begin
        slot_cnt <= slot_cnt + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // enable decision per resource
  // ----------------------------------------------------------------
  generate
    for (gi = 0; gi < NR; gi++) begin : g_en
      logic map_a;
      logic map_b;
      logic slot_on;
      logic base_en;
      assign map_a = en_reg[bdc_pkg::EN_MAP_A_LSB + gi];
      assign map_b = en_reg[bdc_pkg::EN_MAP_B_LSB + gi];
      if (gi < NB) begin : g_slot
        logic [3:0] sl;
        assign sl      = ctrl[gi][bdc_pkg::CTRL_SLOT_LSB +: 4];
        assign slot_on = (sl != 4'h0) && (slot_now >= sl); // R1
      end else begin : g_noslot
        assign slot_on = 1'b0;
      end
      always_comb begin
        if (map_a || map_b) begin
          base_en = (map_a && pins_q[0]) || (map_b && pins_q[1]); // R2 R18
        end else begin
          base_en = en_reg[gi] || slot_on; // R18
        end
      end
      assign en_eff[gi] = base_en && !uvlo_q; // R14
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      res_enable    <= '0;
      res_discharge <= '1;
    end else begin
      res_enable    <= en_eff;
      res_discharge <= ~en_eff; // R15
    end
  end

  // ----------------------------------------------------------------
  // voltage scaling per converter
  // ----------------------------------------------------------------
  generate
    for (gi = 0; gi < NB; gi++) begin : g_dvs
      logic [VW-1:0] tgt;
      logic          use_alt;
      logic          ana;
      assign use_alt = ctrl[gi][bdc_pkg::CTRL_SEL_MAP] && pins_q[2]; // R6
      assign tgt     = use_alt ? volt[gi][bdc_pkg::VOLT_ALT_LSB +: VW]
                               : volt[gi][VW-1:0]; // R19
      assign ana     = (gi == NB - 1) && ctrl[gi][bdc_pkg::CTRL_ANALOG];
      bdc_dvs #(
        .START_CYCLES (START_CYCLES),
        .FAST_CYCLES  (FAST_CYCLES)
      ) u_dvs (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .enable      (en_eff[gi]),
        .fast_start  ((gi == NB - 1) && ctrl[gi][bdc_pkg::CTRL_RAMP_FAST]), // R4
        .direct      (ctrl[gi][bdc_pkg::CTRL_DIRECT]),
        .step_sel    (ctrl[gi][bdc_pkg::CTRL_STEP_LSB +: 3]),
        .analog_mode (ana),
        .target      (tgt),
        .current     (cur_codes[gi*VW +: VW]),
        .soft_start  (buck_ss[gi]),
        .running     (buck_run[gi]),
        .moving      (buck_moving[gi])
      );
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          force_pwm[gi]  <= 1'b0;
          power_good[gi] <= 1'b0;
        end else begin
          force_pwm[gi]  <= buck_moving[gi] || !ctrl[gi][bdc_pkg::CTRL_PSAVE] || ana; // R9 R10
          power_good[gi] <= buck_run[gi] && !buck_moving[gi] && !uv_q[gi]; // R16 R17
        end
      end
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      soft_start   <= '0;
      vout_code    <= '0;
      analog_track <= 1'b0;
    end else begin
      soft_start   <= buck_ss;
      vout_code    <= cur_codes;
      analog_track <= ctrl[NB-1][bdc_pkg::CTRL_ANALOG] && buck_run[NB-1]; // R10
    end
  end

  // ----------------------------------------------------------------
  // switching phase clocks, b trails a by half a period
  // ----------------------------------------------------------------
  logic [7:0] ph_cnt;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ph_cnt      <= 8'h00;
      phase_clk_a <= 1'b0;
      phase_clk_b <= 1'b0;
    end else begin
      ph_cnt      <= (ph_cnt == 8'(bdc_pkg::SW_PERIOD_CYC - 1)) ? 8'h00 : ph_cnt + 8'h01;
      phase_clk_a <= (ph_cnt == 8'h00) && res_enable[0];
      phase_clk_b <= (ph_cnt == 8'(bdc_pkg::SW_HALF_CYC)) && res_enable[1]; // R13
    end
  end
endmodule : bdc_top

//--- verif/bdc_host_model.sv
// host model driving request and select pins
module bdc_host_model (
  input  wire logic aclk,
  input  wire logic want_a,
  input  wire logic want_b,
  input  wire logic want_sel,
  output logic      resource_request_pin_a,
  output logic      resource_request_pin_b,
  output logic      voltage_select_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    resource_request_pin_a = 1'b0;
    resource_request_pin_b = 1'b0;
    voltage_select_pin     = 1'b0;
  end
  // pins move just after an edge, levels held
  always @(posedge aclk) begin
    resource_request_pin_a <= want_a;
    resource_request_pin_b <= want_b;
    voltage_select_pin     <= want_sel;
  end
endmodule : bdc_host_model

//--- verif/bdc_top_properties.sv
// checker for the buck enable and scaling control top
module bdc_top_properties (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        uvlo,
  input wire logic [2:0]  uv_comp,
  input wire logic [4:0]  res_enable,
  input wire logic [4:0]  res_discharge,
  input wire logic [2:0]  soft_start,
  input wire logic [2:0]  force_pwm,
  input wire logic [2:0]  power_good,
  input wire logic [20:0] vout_code,
  input wire logic        analog_track,
  input wire logic        phase_clk_a,
  input wire logic        phase_clk_b
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------------------------------
  // sequences
  // ----------------------------------------
  sequence en_rise;
    $rose(res_enable[0]);
  endsequence
  // code output lags the moving flag by one register stage
  sequence code_step;
    $changed(vout_code[6:0]) && $past(aresetn, 2);
  endsequence
  discharge_tracks_a: assert property (res_discharge == ~res_enable)
    else $error("discharge not inverse of enable");
  uvlo_off_a: assert property (uvlo [*5] |-> res_enable == 5'h00)
    else $error("resource on under lockout");
  start_delay_a: assert property (en_rise |=> (!soft_start[0]) [*8])
    else $error("soft start before delay");
  ss_pulse_a: assert property (soft_start[0] |=> !soft_start[0])
    else $error("soft start pulse too long");
  pwm_move_a: assert property (code_step |-> $past(force_pwm[0]))
    else $error("no forced pwm while moving");
  pg_move_a: assert property (code_step |-> !$past(power_good[0]))
    else $error("power good while moving");
  pg_enabled_a: assert property (power_good[0] |-> res_enable[0] || $past(res_enable[0]))
    else $error("power good while off");
  phase_apart_a: assert property (phase_clk_a |-> !phase_clk_b)
    else $error("both phases together");
  phase_gap_a: assert property (phase_clk_a |=> (!phase_clk_a) [*8])
    else $error("phase a period too short");
  phase_gate_a: assert property (phase_clk_b |-> res_enable[1] || $past(res_enable[1]))
    else $error("phase b while off");
  analog_pwm_a: assert property (analog_track |-> force_pwm[2])
    else $error("analog mode without pwm");
endmodule : bdc_top_properties

bind bdc_top bdc_top_properties u_bdc_top_properties (.*);

//--- verif/bdc_top_tb.sv
// testbench for the buck enable and scaling control top
module bdc_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdat;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic        resource_request_pin_a, resource_request_pin_b, voltage_select_pin;
  logic        want_a = 1'b0, want_b = 1'b0, want_sel = 1'b0;
  logic        power_on = 1'b0, uvlo = 1'b0, analog_track, phase_clk_a, phase_clk_b;
  logic [2:0]  uv_comp = 3'h0, soft_start, force_pwm, power_good;
  logic [4:0]  res_enable, res_discharge;
  logic [20:0] vout_code;
  logic [31:0] obs [4];
  int          errors = 0, samples_checked = 0, n;
  assign obs[0] = {27'h0, res_enable};
  assign obs[1] = {29'h0, soft_start};
  assign obs[2] = {25'h0, vout_code[6:0]};
  assign obs[3] = {29'h0, power_good};
  always #5 aclk = ~aclk;
  bdc_top #(.START_CYCLES(20), .FAST_CYCLES(10), .SLOT_CYCLES(4)) u_bdc_top (.*);
  bdc_host_model u_bdc_host_model (.*);
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic stop_test();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic rng(input int got, input int lo, input int hi);
    samples_checked++;
    if (got < lo || got > hi) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask : rng
  task automatic wait_obs(input int k, input logic [31:0] v, input int lim);
    for (n = 0; n < lim && obs[k] !== v; n++) @(posedge aclk);
    chk(obs[k], v);
    if (obs[k] !== v) stop_test();
  endtask : wait_obs
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 50 && !(s_axi_bvalid && s_axi_bready); i++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (i == 50) begin
      errors++;
      stop_test();
    end
  endtask : wr
  task automatic rd(input logic [7:0] a);
    int i;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 50 && !(s_axi_rvalid && s_axi_rready); i++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    rdat = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (i == 50) begin
      errors++;
      stop_test();
    end
  endtask : rd
  // ----------------------------------------
  // sequence of tests
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(bdc_pkg::ADDR_CTRL0);
    chk(rdat, bdc_pkg::CTRL_RESET);
    rd(bdc_pkg::ADDR_VOLT0);
    chk(rdat, bdc_pkg::VOLT_RESET);
    rd(8'h40);
    chk({30'h0, resp}, {30'h0, bdc_pkg::RESP_SLVERR});
    wr(8'h44, 32'h1);
    chk({30'h0, resp}, {30'h0, bdc_pkg::RESP_SLVERR});
    chk({27'h0, res_discharge}, 32'h1f);
    wr(bdc_pkg::ADDR_ENABLE, 32'h1);
    wait_obs(1, 32'h1, 60);
    rng(n, 18, 30);
    wait_obs(3, 32'h1, 20);
    uv_comp <= 3'h1;
    wait_obs(3, 32'h0, 10);
    uv_comp <= 3'h0;
    wr(bdc_pkg::ADDR_VOLT0, 32'h4043);
    repeat (5) @(posedge aclk);
    chk({31'h0, force_pwm[0]}, 32'h1);
    chk({31'h0, power_good[0]}, 32'h0);
    wait_obs(2, 32'h43, 400);
    rng(n, 90, 160);
    repeat (4) @(posedge aclk);
    chk({31'h0, force_pwm[0]}, 32'h0);
    wr(bdc_pkg::ADDR_CTRL0, 32'h220);
    wr(bdc_pkg::ADDR_VOLT0, 32'h4010);
    wait_obs(2, 32'h10, 10);
    wr(bdc_pkg::ADDR_CTRL1, 32'h220);
    wr(bdc_pkg::ADDR_VOLT1, 32'h3040);
    wr(bdc_pkg::ADDR_ENABLE, 32'h3);
    repeat (20) @(posedge aclk);
    wr(bdc_pkg::ADDR_CTRL0, 32'h230);
    wr(bdc_pkg::ADDR_VOLT0, 32'h2010);
    want_sel <= 1'b1;
    wait_obs(2, 32'h20, 15);
    chk({25'h0, vout_code[13:7]}, 32'h40);
    want_sel <= 1'b0;
    wait_obs(2, 32'h10, 15);
    wr(bdc_pkg::ADDR_CTRL0, 32'h200);
    wr(bdc_pkg::ADDR_ENABLE, 32'h0);
    wait_obs(0, 32'h0, 10);
    wr(bdc_pkg::ADDR_VOLT0, 32'h0015);
    repeat (20) @(posedge aclk);
    chk(obs[2], 32'h10);
    wr(bdc_pkg::ADDR_ENABLE, 32'h1);
    wait_obs(2, 32'h15, 400);
    wr(bdc_pkg::ADDR_ENABLE, 32'h201);
    want_a <= 1'b1;
    wait_obs(0, 32'h3, 10);
    repeat (60) @(posedge aclk);
    want_a <= 1'b0;
    wait_obs(0, 32'h1, 10);
    wr(bdc_pkg::ADDR_ENABLE, 32'h80009);
    wait_obs(0, 32'h1, 10);
    want_b <= 1'b1;
    wait_obs(0, 32'h9, 10);
    want_b <= 1'b0;
    wr(bdc_pkg::ADDR_ENABLE, 32'h1);
    wr(bdc_pkg::ADDR_CTRL2, 32'h603);
    power_on <= 1'b1;
    wait_obs(0, 32'h5, 40);
    rng(n, 8, 20);
    wait_obs(1, 32'h4, 30);
    rng(n, 8, 16);
    wr(bdc_pkg::ADDR_CTRL2, 32'he03);
    repeat (5) @(posedge aclk);
    chk({31'h0, analog_track}, 32'h1);
    chk({31'h0, force_pwm[2]}, 32'h1);
    uvlo <= 1'b1;
    wait_obs(0, 32'h0, 10);
    chk({27'h0, res_discharge}, 32'h1f);
    stop_test();
  end
endmodule : bdc_top_tb
